// [pkg/mgs_pkg.sv]
// constants, types and helpers shared by the magnetometer status and control logic
`default_nettype none
package mgs_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_Z_LOW  = 8'h04;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
  localparam logic [7:0] ADDR_TEMP   = 8'h06;
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  localparam logic [7:0] ADDR_CTRL0  = 8'h08;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned ST_FIELD_DONE = 0;
  localparam int unsigned ST_TEMP_DONE  = 1;
  localparam int unsigned ST_MOTION     = 2;
  localparam int unsigned ST_PUMP       = 3;
  localparam int unsigned ST_OTP_OK     = 4;
  localparam int unsigned CT_FIELD      = 0;
  localparam int unsigned CT_TEMP       = 1;
  localparam int unsigned CT_MOTION     = 2;
  localparam int unsigned CT_COIL_SET   = 3;
  localparam int unsigned CT_COIL_RESET = 4;
  localparam int unsigned CT_OTP        = 6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [3:0]  RATE_OFF     = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
  // periodic rates in micro-hertz, period in ms = 1e9 / rate
  localparam int unsigned UHZ_PER_MS  = 1000000000;
  localparam int unsigned RATE1_UHZ   = 14000000;
  localparam int unsigned RATE2_UHZ   = 5000000;
  localparam int unsigned RATE3_UHZ   = 2200000;
  localparam int unsigned RATE4_UHZ   = 1000000;
  localparam int unsigned RATE5_UHZ   = 500000;
  localparam int unsigned RATE6_UHZ   = 250000;
  localparam int unsigned RATE7_UHZ   = 125000;
  localparam int unsigned RATE8_UHZ   = 62500;
  localparam int unsigned RATE9_UHZ   = 31250;
  localparam int unsigned RATE10_UHZ  = 15625;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } mgs_axes_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } mgs_thresh_t;

  typedef enum logic [2:0] {
    MD_IDLE      = 3'b000,
    MD_BASE_REQ  = 3'b001,
    MD_BASE_WAIT = 3'b010,
    MD_PERIOD    = 3'b011,
    MD_CMP_REQ   = 3'b100,
    MD_CMP_WAIT  = 3'b101
  } mgs_md_state_t;

  // period in ms of a rate code; codes above ten run at the slowest rate
  function automatic logic [15:0] rate_period_ms(input logic [3:0] code);
    int unsigned uhz;
    case (code)
      4'h1:    uhz = RATE1_UHZ;
      4'h2:    uhz = RATE2_UHZ;
      4'h3:    uhz = RATE3_UHZ;
      4'h4:    uhz = RATE4_UHZ;
      4'h5:    uhz = RATE5_UHZ;
      4'h6:    uhz = RATE6_UHZ;
      4'h7:    uhz = RATE7_UHZ;
      4'h8:    uhz = RATE8_UHZ;
      4'h9:    uhz = RATE9_UHZ;
      default: uhz = RATE10_UHZ;
    endcase
    return 16'(UHZ_PER_MS / uhz);
  endfunction

endpackage
`default_nettype wire

// [rtl/mgs_rate_timer.sv]
// periodic tick generator for the motion watch
`timescale 1ns/1ps
`default_nettype none
module mgs_rate_timer #(
  parameter int unsigned CYC_PER_MS = mgs_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic [3:0] rate,
  // event
  output logic            tick
);

  localparam int unsigned DW = $clog2(CYC_PER_MS + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(CYC_PER_MS - 1);

  logic [DW-1:0] div_q;
  logic [15:0]   ms_q;
  wire           ms_end  = (div_q == DIV_LAST);
  wire  [15:0]   per_ms  = mgs_pkg::rate_period_ms(rate);
  wire           per_end = ms_end && (ms_q == per_ms - 16'h0001);

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      div_q <= '0;
      ms_q  <= '0;
    end else if (ce) begin
      div_q <= ms_end ? '0 : div_q + DW'(1);
      if (per_end) begin
        ms_q <= '0;
      end else if (ms_end) begin
        ms_q <= ms_q + 16'h0001;
      end
    end
  end

  assign tick = run && ce && per_end;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_tick_needs_run;
    @(posedge clk) disable iff (rst) tick |-> run && ms_end;
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick while idle");

endmodule
`default_nettype wire

// [rtl/mgs_status_ctrl.sv]
// status, result and measurement-command registers of the magnetometer core
// Contract
// - z result readable as low byte 04h and high byte 05h, read only.
// - eight-bit die temperature code readable at 06h, read only.
// - field done bit clears on new command, sets at finish, holds.
// - temperature done bit clears on new command, sets at finish, holds.
// - writing one to a done bit clears its interrupt; zero does nothing.
// - motion bit sets on detected change; writing one clears it.
// - status bit 3 shows the charge pump is active.
// - status bit 4 shows a successful memory read.
// - control bit 0 starts a field measurement and self-clears.
// - control bit 1 starts a temperature measurement and self-clears.
// - motion start takes baseline, then measures periodically and compares.
// - difference above any axis threshold sets the motion bit.
// - periodic interval follows the rate select field.
// - motion start bit returns to zero once motion is detected.
// - control bit 3 fires a forward coil pulse.
// - control bit 4 fires a reverse coil pulse.
// - control bit 6 reloads programmable memory and self-clears.
// - interrupt pin active high, undriven until a source is enabled.
// - only accesses carrying this device address are answered.
// - rate select zero stops the motion detector.
`timescale 1ns/1ps
`default_nettype none
module mgs_status_ctrl #(
  parameter logic [6:0]  DEV_ADDR   = 7'h30,  // arbitrary default
  parameter int unsigned CYC_PER_MS = mgs_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic                CORE_CLK,
  input  wire logic                SYS_RST,
  input  wire logic                CORE_CE,
  // decoded register access from the serial slave
  input  wire logic [6:0]          REG_DEV_ADDR,
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic                REG_WR,
  input  wire logic [7:0]          REG_WDATA,
  input  wire logic                REG_RD,
  output logic                     REG_ACK,
  output logic [7:0]               REG_RDATA,
  // field conversion
  output logic                     FIELD_REQ,
  input  wire logic                FIELD_DONE,
  input  wire mgs_pkg::mgs_axes_t  FIELD_DATA,
  // temperature conversion
  output logic                     TEMP_REQ,
  input  wire logic                TEMP_DONE,
  input  wire logic [7:0]          TEMP_DATA,
  // set/reset coil
  output logic                     COIL_SET_REQ,
  output logic                     COIL_RESET_REQ,
  input  wire logic                COIL_DONE,
  // programmable memory and pump
  output logic                     OTP_RELOAD_REQ,
  input  wire logic                OTP_DONE,
  input  wire logic                OTP_OK,
  input  wire logic                PUMP_ACTIVE,
  // configuration held elsewhere
  input  wire logic [3:0]          PERIODIC_RATE_SELECT,
  input  wire mgs_pkg::mgs_thresh_t MOTION_THRESH,
  input  wire logic                FIELD_INT_EN,
  input  wire logic                MOTION_INT_EN,
  // interrupt pin
  output logic                     INT_O,
  output logic                     INT_OE
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic over_thresh(input logic [15:0] a, input logic [15:0] b,
                                       input logic [7:0] thr);
    logic [15:0] d;
    d = (a > b) ? a - b : b - a;
    return d > {8'h00, thr};
  endfunction

  // ****************************************************************
  // access decode
  // ****************************************************************
  mgs_pkg::mgs_md_state_t md_q;
  mgs_pkg::mgs_md_state_t md_d;
  mgs_pkg::mgs_axes_t     base_q;
  logic [15:0] z_q;
  logic [7:0]  temp_q;
  logic        field_done_q;
  logic        temp_done_q;
  logic        field_int_q;
  logic        temp_int_q;
  logic        motion_q;
  logic        pump_q;
  logic        otp_ok_q;
  logic        otp_busy_q;
  logic        coil_set_q;
  logic        coil_reset_q;
  logic        field_req_q;
  logic        temp_req_q;
  logic        int_q;
  logic [7:0]  rdata_q;
  logic        tick;

  wire dev_hit   = (REG_DEV_ADDR == DEV_ADDR);
  wire wr_hit    = REG_WR && dev_hit;
  wire rd_hit    = REG_RD && dev_hit;
  wire wr_status = wr_hit && (REG_ADDR == mgs_pkg::ADDR_STATUS);
  wire wr_ctrl   = wr_hit && (REG_ADDR == mgs_pkg::ADDR_CTRL0);
  wire rate_on   = (PERIODIC_RATE_SELECT != mgs_pkg::RATE_OFF);

  // field wins if the host sets both triggers
  wire host_field_cmd = wr_ctrl && REG_WDATA[mgs_pkg::CT_FIELD];
  wire host_temp_cmd  = wr_ctrl && REG_WDATA[mgs_pkg::CT_TEMP] && !REG_WDATA[mgs_pkg::CT_FIELD];
  // start refused while periodic rate is off
  wire motion_cmd     = wr_ctrl && REG_WDATA[mgs_pkg::CT_MOTION] && rate_on;
  wire coil_idle      = !coil_set_q && !coil_reset_q;
  wire coil_set_cmd   = wr_ctrl && REG_WDATA[mgs_pkg::CT_COIL_SET] && coil_idle;
  // reverse pulse, forward wins on a joint write
  wire coil_reset_cmd = wr_ctrl && REG_WDATA[mgs_pkg::CT_COIL_RESET] && coil_idle
                        && !REG_WDATA[mgs_pkg::CT_COIL_SET];
  wire otp_cmd        = wr_ctrl && REG_WDATA[mgs_pkg::CT_OTP];
  wire md_field_cmd   = (md_q == mgs_pkg::MD_BASE_REQ) || (md_q == mgs_pkg::MD_CMP_REQ);
  wire field_cmd      = host_field_cmd || md_field_cmd;

  // write-one clears, a same-cycle set still wins
  wire clr_field_int  = wr_status && REG_WDATA[mgs_pkg::ST_FIELD_DONE];
  wire clr_temp_int   = wr_status && REG_WDATA[mgs_pkg::ST_TEMP_DONE];
  wire clr_motion     = wr_status && REG_WDATA[mgs_pkg::ST_MOTION];

  wire exceeds = over_thresh(FIELD_DATA.x, base_q.x, MOTION_THRESH.x)
              || over_thresh(FIELD_DATA.y, base_q.y, MOTION_THRESH.y)
              || over_thresh(FIELD_DATA.z, base_q.z, MOTION_THRESH.z);
  wire motion_hit = (md_q == mgs_pkg::MD_CMP_WAIT) && FIELD_DONE && exceeds && rate_on;

  // ****************************************************************
  // motion watch sequencer
  // ****************************************************************
  // baseline, periodic compare loop
  always_comb begin
    md_d = md_q;
    case (md_q)
      mgs_pkg::MD_IDLE:      if (motion_cmd) md_d = mgs_pkg::MD_BASE_REQ;
      mgs_pkg::MD_BASE_REQ:  md_d = mgs_pkg::MD_BASE_WAIT;
      mgs_pkg::MD_BASE_WAIT: if (FIELD_DONE) md_d = mgs_pkg::MD_PERIOD;
      mgs_pkg::MD_PERIOD:    if (tick) md_d = mgs_pkg::MD_CMP_REQ;
      mgs_pkg::MD_CMP_REQ:   md_d = mgs_pkg::MD_CMP_WAIT;
      mgs_pkg::MD_CMP_WAIT: begin
        if (FIELD_DONE) md_d = exceeds ? mgs_pkg::MD_IDLE : mgs_pkg::MD_PERIOD;
      end
      default:               md_d = mgs_pkg::MD_IDLE;
    endcase
    if (!rate_on) md_d = mgs_pkg::MD_IDLE;
  end

  mgs_rate_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .ce   (CORE_CE),
    .run  (md_q == mgs_pkg::MD_PERIOD),
    .rate (PERIODIC_RATE_SELECT),
    .tick (tick)
  );

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      md_q   <= mgs_pkg::MD_IDLE;
      base_q <= '0;
    end else if (CORE_CE) begin
      md_q <= md_d;
      if (md_q == mgs_pkg::MD_BASE_WAIT && FIELD_DONE) base_q <= FIELD_DATA;
    end
  end

  // ****************************************************************
  // results and status flags
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      z_q          <= mgs_pkg::RESULT_RESET;
      temp_q       <= mgs_pkg::BYTE_ZERO;
      field_done_q <= 1'b0;
      temp_done_q  <= 1'b0;
      field_int_q  <= 1'b0;
      temp_int_q   <= 1'b0;
      motion_q     <= 1'b0;
      pump_q       <= 1'b0;
      otp_ok_q     <= 1'b0;
    end else if (CORE_CE) begin
      if (FIELD_DONE) z_q <= FIELD_DATA.z;
      if (TEMP_DONE) temp_q <= TEMP_DATA;
      field_done_q <= FIELD_DONE || (field_done_q && !field_cmd);
      temp_done_q  <= TEMP_DONE || (temp_done_q && !host_temp_cmd);
      field_int_q  <= FIELD_DONE || (field_int_q && !clr_field_int);
      temp_int_q   <= TEMP_DONE || (temp_int_q && !clr_temp_int);
      motion_q     <= motion_hit || (motion_q && !clr_motion);
      pump_q       <= PUMP_ACTIVE;
      otp_ok_q     <= (OTP_DONE && OTP_OK) || (otp_ok_q && !otp_cmd);
    end
  end

  // ****************************************************************
  // command requests
  // ****************************************************************
  // coil and reload requests stay up until the analogue side answers;
  // field and temperature requests are single-cycle pulses
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      field_req_q  <= 1'b0;
      temp_req_q   <= 1'b0;
      coil_set_q   <= 1'b0;
      coil_reset_q <= 1'b0;
      otp_busy_q   <= 1'b0;
    end else if (CORE_CE) begin
      field_req_q  <= field_cmd;
      temp_req_q   <= host_temp_cmd;
      coil_set_q   <= coil_set_cmd || (coil_set_q && !COIL_DONE);
      coil_reset_q <= coil_reset_cmd || (coil_reset_q && !COIL_DONE);
      // reload request until memory read ends
      otp_busy_q   <= otp_cmd || (otp_busy_q && !OTP_DONE);
    end
  end

  assign FIELD_REQ      = field_req_q;
  assign TEMP_REQ       = temp_req_q;
  assign COIL_SET_REQ   = coil_set_q;
  assign COIL_RESET_REQ = coil_reset_q;
  assign OTP_RELOAD_REQ = otp_busy_q;

  // ****************************************************************
  // read path and interrupt pin
  // ****************************************************************
  wire [7:0] status_byte = {3'b000, otp_ok_q, pump_q, motion_q, temp_done_q, field_done_q};
  // control register is write-only and reads as zero
  wire [7:0] rd_word =
      (REG_ADDR == mgs_pkg::ADDR_Z_LOW)  ? z_q[7:0]    :
      (REG_ADDR == mgs_pkg::ADDR_Z_HIGH) ? z_q[15:8]   :
      (REG_ADDR == mgs_pkg::ADDR_TEMP)   ? temp_q      :
      (REG_ADDR == mgs_pkg::ADDR_STATUS) ? status_byte : mgs_pkg::BYTE_ZERO;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_q <= mgs_pkg::BYTE_ZERO;
      int_q   <= 1'b0;
    end else if (CORE_CE) begin
      if (rd_hit) rdata_q <= rd_word;
      int_q <= (FIELD_INT_EN && (field_int_q || temp_int_q)) || (MOTION_INT_EN && motion_q);
    end
  end

  assign REG_ACK   = wr_hit || rd_hit;
  assign REG_RDATA = rdata_q;
  assign INT_O     = int_q;
  // pin driven only once a source is enabled
  assign INT_OE    = FIELD_INT_EN || MOTION_INT_EN;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_z_capture;
    CORE_CE && FIELD_DONE |=> z_q == $past(FIELD_DATA.z);
  endproperty
  a_z_capture: assert property (p_z_capture) else $error("z result not captured");

  property p_field_done_clear;
    CORE_CE && field_cmd && !FIELD_DONE |=> !field_done_q
      ##1 (field_done_q || !($past(FIELD_DONE) && $past(CORE_CE)));
  endproperty
  a_field_done_clear: assert property (p_field_done_clear) else $error("field done kept");

  property p_temp_done_set;
    CORE_CE && TEMP_DONE |=> temp_done_q && temp_q == $past(TEMP_DATA);
  endproperty
  a_temp_done_set: assert property (p_temp_done_set) else $error("temp done not set");

  property p_int_clear;
    CORE_CE && clr_field_int && !FIELD_DONE && !TEMP_DONE && !temp_int_q && !MOTION_INT_EN
      |=> ##1 !INT_O;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");

  property p_motion_set;
    CORE_CE && motion_hit |=> motion_q && md_q == mgs_pkg::MD_IDLE;
  endproperty
  a_motion_set: assert property (p_motion_set) else $error("motion not flagged");

  property p_field_trigger;
    CORE_CE && host_field_cmd |=> FIELD_REQ ##1 (!FIELD_REQ || $past(field_cmd));
  endproperty
  a_field_trigger: assert property (p_field_trigger) else $error("field request wrong");

  property p_temp_trigger;
    CORE_CE && wr_ctrl && REG_WDATA[mgs_pkg::CT_TEMP]
      |=> TEMP_REQ != $past(REG_WDATA[mgs_pkg::CT_FIELD]);
  endproperty
  a_temp_trigger: assert property (p_temp_trigger) else $error("temp request wrong");

  property p_coil_release;
    CORE_CE && COIL_DONE && !coil_set_cmd |=> !COIL_SET_REQ;
  endproperty
  a_coil_release: assert property (p_coil_release) else $error("coil request stuck");

  property p_rate_off;
    CORE_CE && !rate_on |=> md_q == mgs_pkg::MD_IDLE && !motion_hit;
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("detector ran with rate off");

  property p_foreign_addr;
    !dev_hit |-> !REG_ACK;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign access answered");

  c_motion: cover property (CORE_CE && motion_hit);
  c_compare_pass: cover property (md_q == mgs_pkg::MD_CMP_WAIT && FIELD_DONE && !exceeds);
  c_otp_ok: cover property (OTP_RELOAD_REQ ##[1:20] otp_ok_q);
  c_coil: cover property (COIL_RESET_REQ ##1 !COIL_RESET_REQ);
  c_ce_hold: cover property (!CORE_CE && wr_ctrl);

endmodule
`default_nettype wire

// [sim/mgs_far_model.sv]
// behavioural conversion, coil and memory engines behind the control block
`timescale 1ns/1ps
`default_nettype none
module mgs_far_model #(
  parameter int DLY = 5
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // requests
  input  wire logic               field_req,
  input  wire logic               temp_req,
  input  wire logic               coil_req,
  input  wire logic               otp_req,
  // values to report
  input  wire mgs_pkg::mgs_axes_t fld_val,
  input  wire logic [7:0]         tmp_val,
  // answers
  output logic                    field_done,
  output logic                    temp_done,
  output logic                    coil_done,
  output logic                    otp_done,
  output mgs_pkg::mgs_axes_t      fld_data,
  output logic [7:0]              tmp_data
);
  int fc;
  int tc;
  int cc;
  int oc;
  // data is only valid with its done pulse, so show garbage otherwise
  assign fld_data = field_done ? fld_val : ~fld_val;
  assign tmp_data = temp_done ? tmp_val : ~tmp_val;
  always @(posedge clk) begin
    if (rst) begin
      fc <= 0;
      tc <= 0;
      cc <= 0;
      oc <= 0;
      field_done <= 1'b0;
      temp_done <= 1'b0;
      coil_done <= 1'b0;
      otp_done <= 1'b0;
    end else begin
      fc <= field_req ? DLY : (fc > 0 ? fc - 1 : 0);
      tc <= temp_req ? DLY : (tc > 0 ? tc - 1 : 0);
      cc <= (coil_req && !coil_done) ? cc + 1 : 0;
      oc <= (otp_req && !otp_done) ? oc + 1 : 0;
      field_done <= (fc == 1);
      temp_done <= (tc == 1);
      // level requests get one done pulse only
      coil_done <= (cc == DLY) && !coil_done;
      otp_done <= (oc == DLY) && !otp_done;
    end
  end
endmodule
`default_nettype wire

// [sim/test_mgs_status_ctrl.sv]
// self-checking bench for the magnetometer status and control registers
`timescale 1ns/1ps
`default_nettype none
module test_mgs_status_ctrl;
  localparam logic [6:0] DEV = 7'h30;  // arbitrary address
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, pump = 1'b0;
  logic fen = 1'b0, men = 1'b0, ack, freq, fdone, treq, tdone, cset, crst, cdone;
  logic oreq, odone, into, intoe, ook = 1'b1;
  logic [6:0] dev = DEV;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, tval = 8'h00, tdat;
  logic [3:0] rate = 4'h0;
  mgs_pkg::mgs_thresh_t thr = 24'h101010;
  mgs_pkg::mgs_axes_t fval = 48'h0, fdat;
  int n_fail = 0, total_checks = 0, n_freq = 0, n0;
  always #20 clk = ~clk;
  always @(posedge clk) if (freq === 1'b1) n_freq <= n_freq + 1;
  mgs_status_ctrl #(.DEV_ADDR(DEV), .CYC_PER_MS(4)) u_mgs_status_ctrl (
    .CORE_CLK(clk), .SYS_RST(rst), .CORE_CE(ce), .REG_DEV_ADDR(dev), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_ACK(ack), .REG_RDATA(rdata),
    .FIELD_REQ(freq), .FIELD_DONE(fdone), .FIELD_DATA(fdat), .TEMP_REQ(treq),
    .TEMP_DONE(tdone), .TEMP_DATA(tdat), .COIL_SET_REQ(cset), .COIL_RESET_REQ(crst),
    .COIL_DONE(cdone), .OTP_RELOAD_REQ(oreq), .OTP_DONE(odone), .OTP_OK(ook),
    .PUMP_ACTIVE(pump), .PERIODIC_RATE_SELECT(rate), .MOTION_THRESH(thr),
    .FIELD_INT_EN(fen), .MOTION_INT_EN(men), .INT_O(into), .INT_OE(intoe));
  mgs_far_model u_mgs_far_model (
    .clk(clk), .rst(rst), .field_req(freq), .temp_req(treq), .coil_req(cset | crst),
    .otp_req(oreq), .fld_val(fval), .tmp_val(tval), .field_done(fdone),
    .temp_done(tdone), .coil_done(cdone), .otp_done(odone), .fld_data(fdat),
    .tmp_data(tdat));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic acc(logic [6:0] d, logic w, logic [7:0] a, logic [7:0] v, output logic [7:0] q);
    @(posedge clk);
    dev <= d;
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    #1 check("ack", ack, d == DEV);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    dev <= DEV;
    @(posedge clk);
    #1 q = rdata;
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] v);
    logic [7:0] q;
    acc(DEV, 1'b1, a, v, q);
  endtask
  task automatic rchk(string what, logic [7:0] a, logic [7:0] m, logic [7:0] e);
    logic [7:0] q;
    acc(DEV, 1'b0, a, 8'h00, q);
    check(what, q & m, e);
  endtask
  task automatic poll(logic [7:0] m);
    logic [7:0] q;
    for (int i = 0; i < 400; i++) begin
      acc(DEV, 1'b0, 8'h07, 8'h00, q);
      if ((q & m) === m) return;
    end
    n_fail++;
    $display("[ERR] status wait expected %h seen %h", m, q);
    stop_test();
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] q;
    for (int a = 4; a <= 8; a++) rchk("reset", 8'(a), 8'hff, 8'h00);
    rchk("unmapped", 8'h20, 8'hff, 8'h00);
    check("int oe", intoe, 1'b0);
    acc(7'h31, 1'b1, 8'h08, 8'h01, q);
    repeat (10) @(posedge clk);
    check("foreign", n_freq, 0);
  endtask
  task automatic t_field();
    fen <= 1'b1;
    fval.z <= 16'hbeef;
    wreg(8'h08, 8'h01);
    #1 check("int oe", intoe, 1'b1);
    rchk("busy", 8'h07, 8'h01, 8'h00);
    poll(8'h01);
    check("reqs", n_freq, 1);
    check("int", into, 1'b1);
    rchk("z low", 8'h04, 8'hff, 8'hef);
    rchk("z high", 8'h05, 8'hff, 8'hbe);
    wreg(8'h04, 8'h00);
    rchk("z ro", 8'h04, 8'hff, 8'hef);
    wreg(8'h07, 8'h00);
    #1 check("int kept", into, 1'b1);
    wreg(8'h07, 8'h01);
    #1 check("int clr", into, 1'b0);
    rchk("done held", 8'h07, 8'h01, 8'h01);
  endtask
  task automatic t_temp();
    tval <= 8'h5a;
    wreg(8'h08, 8'h02);
    rchk("busy", 8'h07, 8'h02, 8'h00);
    poll(8'h02);
    rchk("temp", 8'h06, 8'hff, 8'h5a);
    rchk("ctrl", 8'h08, 8'hff, 8'h00);
    check("no field", n_freq, 1);
    check("temp int", into, 1'b1);
    wreg(8'h07, 8'h02);
    #1 check("temp int clr", into, 1'b0);
    ce <= 1'b0;
    wreg(8'h08, 8'h02);
    ce <= 1'b1;
    rchk("frozen", 8'h07, 8'h02, 8'h02);
  endtask
  task automatic t_coil();
    wreg(8'h08, 8'h08);
    #1 check("set", cset, 1'b1);
    repeat (10) @(posedge clk);
    #1 check("set end", cset, 1'b0);
    wreg(8'h08, 8'h10);
    #1 check("reset", crst, 1'b1);
    repeat (10) @(posedge clk);
    #1 check("reset end", crst, 1'b0);
    wreg(8'h08, 8'h40);
    #1 check("reload", oreq, 1'b1);
    poll(8'h10);
    check("reload end", oreq, 1'b0);
    ook <= 1'b0;
    wreg(8'h08, 8'h40);
    repeat (10) @(posedge clk);
    #1 check("bad end", oreq, 1'b0);
    rchk("reload bad", 8'h07, 8'h10, 8'h00);
    ook <= 1'b1;
    pump <= 1'b1;
    rchk("pump", 8'h07, 8'h08, 8'h08);
    pump <= 1'b0;
    rchk("pump off", 8'h07, 8'h08, 8'h00);
  endtask
  task automatic t_motion();
    men <= 1'b1;
    fen <= 1'b0;
    rate <= 4'h1;
    fval <= {3{16'h1000}};
    n0 = n_freq;
    wreg(8'h08, 8'h04);
    repeat (40) @(posedge clk);
    check("baseline", n_freq, n0 + 1);
    fval.z <= 16'h1020;
    repeat (200) @(posedge clk);
    rchk("early", 8'h07, 8'h04, 8'h00);
    check("int early", into, 1'b0);
    poll(8'h04);
    check("compare", n_freq, n0 + 2);
    check("int", into, 1'b1);
    repeat (400) @(posedge clk);
    check("stopped", n_freq, n0 + 2);
    wreg(8'h07, 8'h04);
    rchk("motion clr", 8'h07, 8'h04, 8'h00);
    rate <= 4'h0;
    wreg(8'h08, 8'h04);
    repeat (400) @(posedge clk);
    check("rate off", n_freq, n0 + 2);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_field();
    t_temp();
    t_coil();
    t_motion();
    stop_test();
  end
endmodule
`default_nettype wire
